// [src/byte_mem.sv]
`timescale 1ns/100ps
module byte_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  // clock
  input  wire logic          clk,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read side
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  // no reset: contents stand for nonvolatile cells
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule : byte_mem

// [src/sigsec_access.sv]
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module sigsec_access
  import sigsec_pkg::*;
#(
  parameter logic [7:0] MFR_CODE  = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_CODE  = 8'h3c, // arbitrary value
  parameter logic [7:0] MFR2_CODE = 8'h6b, // arbitrary value
  parameter logic [7:0] DEV2_CODE = 8'h4d  // arbitrary value
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // control pins
  input  wire logic        chip_reset_pin,
  input  wire logic        test_input_zero,
  input  wire logic        sync_select_hv,
  input  wire logic        program_enable_pin,
  input  wire logic        prog_n,
  // address and data pins
  input  wire logic [7:0]  bus_lines_in,
  output logic      [7:0]  bus_lines_out,
  output logic             bus_lines_oe,
  input  wire logic [7:0]  port_one_in,
  input  wire logic [3:0]  port_two_in,
  // time state
  output logic      [2:0]  time_state,
  output logic      [1:0]  time_phase
);
  typedef enum logic [1:0] {SY_RUN, SY_HOLD, SY_REL} sync_st_e;

  logic              rst_q_r;
  logic              prog_q_r;
  logic [ADDR_W-1:0] addr_r;
  logic              sec_bit_r;
  logic [7:0]        sec_byte_r;
  logic [7:0]        bus_out_r;
  logic              oe_r;
  logic              otp_r;
  logic [2:0]        t0_cnt_r;
  logic              armed_r;
  sync_st_e          sync_st_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic [7:0]        arr_rdata;
  logic [7:0]        sig_rdata;
  logic [2:0]        ts;
  logic [1:0]        ph;
  logic              sync_mode;
  logic              sig_sel;
  logic              sig_in_row;
  sig_region_e       region;
  logic              prog_fall;
  logic              wr_ok;
  logic              arr_we;
  logic              sig_we;
  logic              sec_we;
  logic              hold;
  logic [7:0]        rd_byte;
  logic              apb_setup;
  logic              apb_wr;
  logic [31:0]       status;

  // pin decode
  assign sync_mode  = sync_select_hv && !program_enable_pin;
  assign sig_sel    = (port_one_in == SIG_P1_CODE) &&
                      (port_two_in[2:0] == SIG_P2_LOW);
  assign sig_in_row = (addr_r[ADDR_W-1:SIG_AW] == '0);
  assign region     = sig_region(addr_r[SIG_AW-1:0]);
  assign prog_fall  = prog_q_r && !prog_n;

  // program strobe only counts with reset high and test input low
  assign wr_ok  = program_enable_pin && chip_reset_pin && !test_input_zero &&
                  prog_fall;
  assign arr_we = wr_ok && !sig_sel;
  assign sig_we = wr_ok && sig_sel && sig_in_row &&
                  sig_writable(region, otp_r);
  assign sec_we = wr_ok && sig_sel && sig_in_row && (region == RG_SEC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q_r  <= 1'b0;
      prog_q_r <= 1'b1;
    end else begin
      rst_q_r  <= chip_reset_pin;
      prog_q_r <= prog_n;
    end
  end

  // address latch on the rising reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= '0;
    end else if (program_enable_pin && chip_reset_pin && !rst_q_r) begin
      addr_r <= {port_two_in, bus_lines_in};
    end
  end

  // security cell and its signature byte are written together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_bit_r  <= 1'b0;
      sec_byte_r <= BLANK_BYTE;
    end else if (sec_we) begin
      sec_bit_r  <= 1'b1;
      sec_byte_r <= bus_lines_in;
    end
  end

  byte_mem #(.AW(ADDR_W), .DW(DATA_W)) u_array (
    .clk   (pclk),
    .we    (arr_we),
    .waddr (addr_r),
    .wdata (bus_lines_in),
    .raddr (addr_r),
    .rdata (arr_rdata)
  );

  byte_mem #(.AW(SIG_AW), .DW(DATA_W)) u_sig_row (
    .clk   (pclk),
    .we    (sig_we),
    .waddr (addr_r[SIG_AW-1:0]),
    .wdata (bus_lines_in),
    .raddr (addr_r[SIG_AW-1:0]),
    .rdata (sig_rdata)
  );

  // read selection; array data take one cycle after an address change
  always_comb begin
    rd_byte = BLANK_BYTE;
    if (sig_sel) begin
      if (!sig_in_row) begin
        rd_byte = BLANK_BYTE;
      end else begin
        case (region)
          RG_MFR:  rd_byte = MFR_CODE;
          RG_DEV:  rd_byte = DEV_CODE;
          RG_MFR2: rd_byte = MFR2_CODE;
          RG_DEV2: rd_byte = DEV2_CODE;
          RG_SEC:  rd_byte = sec_bit_r ? sec_byte_r : BLANK_BYTE;
          RG_USER: rd_byte = otp_r ? sig_rdata : BLANK_BYTE;
          default: rd_byte = sig_rdata;
        endcase
      end
    end else begin
      rd_byte = sec_bit_r ? LOCKED_BYTE : arr_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_out_r <= BLANK_BYTE;
      oe_r      <= 1'b0;
    end else begin
      bus_out_r <= rd_byte;
      oe_r      <= program_enable_pin && chip_reset_pin && test_input_zero;
    end
  end

  // sync: hold prescaler while test input is high, then two more clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_st_r <= SY_RUN;
    end else begin
      case (sync_st_r)
        SY_RUN:  if (sync_mode && test_input_zero) sync_st_r <= SY_HOLD;
        SY_HOLD: if (!sync_mode) sync_st_r <= SY_RUN;
                 else if (!test_input_zero) sync_st_r <= SY_REL;
        SY_REL:  sync_st_r <= SY_RUN;
        default: sync_st_r <= SY_RUN;
      endcase
    end
  end

  // a short pulse still holds the prescaler; armed tells software it was long enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_cnt_r <= 3'h0;
      armed_r  <= 1'b0;
    end else if (sync_mode && test_input_zero) begin
      if (t0_cnt_r != T0_MIN) t0_cnt_r <= t0_cnt_r + 3'h1;
      armed_r <= (t0_cnt_r >= T0_MIN - 3'h1);
    end else if (!sync_mode) begin
      t0_cnt_r <= 3'h0;
      armed_r  <= 1'b0;
    end else begin
      t0_cnt_r <= 3'h0;
    end
  end

  assign hold = (sync_st_r != SY_RUN) ||
                (sync_mode && test_input_zero);

  time_state_gen u_tsg (
    .clk   (pclk),
    .rst_n (presetn),
    .hold  (hold),
    .ts_r  (ts),
    .ph_r  (ph)
  );

  // apb: zero-wait, answer registered at the setup edge
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready_r && pwrite;

  always_comb begin
    status              = '0;
    status[ST_SEC]      = sec_bit_r;
    status[ST_SIG]      = sig_sel;
    status[ST_SYNC]     = sync_mode;
    status[ST_ARM]      = armed_r;
    status[ST_TS+:3]    = ts;
    status[ST_PH+:2]    = ph;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otp_r <= CTRL_RST;
    end else if (apb_wr && paddr == CTRL_OFF) begin
      otp_r <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup && !(paddr == CTRL_OFF || paddr == STAT_OFF ||
                                  paddr == ADDR_OFF);
      if (apb_setup) begin
        case (paddr)
          CTRL_OFF: prdata_r <= {31'h0, otp_r};
          STAT_OFF: prdata_r <= status;
          ADDR_OFF: prdata_r <= {20'h0, addr_r};
          default:  prdata_r <= '0;
        endcase
      end
    end
  end

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign bus_lines_out = bus_out_r;
  assign bus_lines_oe  = oe_r;
  assign time_state    = ts;
  assign time_phase    = ph;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_sec_unprog;
    (sig_sel && sig_in_row && region == RG_SEC && !sec_bit_r) |=> bus_out_r == BLANK_BYTE;
  endproperty
  a_sec_unprog: assert property (p_sec_unprog) else $error("unset security byte not 00");

  property p_sec_prog;
    sec_we |=> sec_bit_r && sec_byte_r == $past(bus_lines_in);
  endproperty
  a_sec_prog: assert property (p_sec_prog) else $error("security byte not written");

  property p_locked;
    (sec_bit_r && !sig_sel) |=> bus_out_r == LOCKED_BYTE;
  endproperty
  a_locked: assert property (p_locked) else $error("array readable while locked");

  property p_mfr;
    (sig_sel && sig_in_row && addr_r[5:0] == MFR_AD) |=> bus_out_r == MFR_CODE;
  endproperty
  a_mfr: assert property (p_mfr) else $error("manufacturer code wrong");

  property p_dev2;
    (sig_sel && sig_in_row && addr_r[5:0] == DEV2_AD) |=> bus_out_r == DEV2_CODE;
  endproperty
  a_dev2: assert property (p_dev2) else $error("second device code wrong");

  property p_blank;
    (sig_sel && !sig_in_row) |=> bus_out_r == BLANK_BYTE;
  endproperty
  a_blank: assert property (p_blank) else $error("outside row not blank");

  property p_latch;
    (program_enable_pin && $rose(chip_reset_pin)) |=>
      addr_r == $past({port_two_in, bus_lines_in});
  endproperty
  a_latch: assert property (p_latch) else $error("address not latched");

  property p_sync_start;
    (sync_st_r == SY_HOLD && sync_mode && !test_input_zero) ##1 !test_input_zero
      |=> ##1 ts == 3'h1 && ph == 2'h1;
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("sync start not 2 clocks");

  property p_user_gate;
    (sig_sel && sig_in_row && region == RG_USER && !otp_r) |=> bus_out_r == BLANK_BYTE;
  endproperty
  a_user_gate: assert property (p_user_gate) else $error("user bytes on rom");

  property p_drive;
    (program_enable_pin && chip_reset_pin && test_input_zero) [*2] |=> bus_lines_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("verify data not driven");

  c_sec_prog: cover property (sec_we);
  c_sync: cover property (sync_st_r == SY_REL ##1 ts == 3'h0 ##1 ts == 3'h1);
  c_locked_rd: cover property (sec_bit_r && bus_lines_oe && !sig_sel);
endmodule : sigsec_access

// [src/sigsec_pkg.sv]
package sigsec_pkg;
  // widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int SIG_AW = 6;

  // pin access codes
  localparam logic [7:0] SIG_P1_CODE = 8'hfe;
  localparam logic [2:0] SIG_P2_LOW  = 3'h0;

  // signature row map
  localparam logic [5:0] TEST_HI   = 6'h0f;
  localparam logic [5:0] MFR_AD    = 6'h10;
  localparam logic [5:0] DEV_AD    = 6'h11;
  localparam logic [5:0] USR_LO    = 6'h12;
  localparam logic [5:0] USR_HI    = 6'h13;
  localparam logic [5:0] TSIG_LO   = 6'h14;
  localparam logic [5:0] TSIG_HI   = 6'h15;
  localparam logic [5:0] TEST2_LO  = 6'h16;
  localparam logic [5:0] TEST2_HI  = 6'h1e;
  localparam logic [5:0] SEC_AD    = 6'h1f;
  localparam logic [5:0] MFR2_AD   = 6'h20;
  localparam logic [5:0] DEV2_AD   = 6'h21;
  localparam logic [5:0] UDEF_LO   = 6'h22;
  localparam logic [5:0] UDEF_HI   = 6'h3e;
  localparam logic [5:0] SEC_ALIAS = 6'h3f;

  // read values
  localparam logic [7:0] BLANK_BYTE  = 8'h00;
  localparam logic [7:0] LOCKED_BYTE = 8'hff;

  // time state generator
  localparam logic [1:0] PHASES    = 2'h3;
  localparam logic [2:0] STATES    = 3'h5;
  localparam logic [2:0] T0_MIN    = 3'h4;
  localparam int         TCY_CLK   = 15;
  localparam int         RUN_DELAY = 5 * TCY_CLK;

  // apb map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] ADDR_OFF = 8'h08;
  localparam logic       CTRL_RST = 1'b1;
  localparam int         ST_SEC   = 0;
  localparam int         ST_SIG   = 1;
  localparam int         ST_SYNC  = 2;
  localparam int         ST_ARM   = 3;
  localparam int         ST_TS    = 4;
  localparam int         ST_PH    = 8;

  typedef enum logic [3:0] {
    RG_TEST, RG_MFR, RG_DEV, RG_USER, RG_TSIG, RG_SEC, RG_MFR2, RG_DEV2, RG_UDEF
  } sig_region_e;

  function automatic sig_region_e sig_region(input logic [5:0] a);
    sig_region_e r;
    r = RG_UDEF;
    if (a <= TEST_HI || (a >= TEST2_LO && a <= TEST2_HI)) r = RG_TEST;
    else if (a == MFR_AD) r = RG_MFR;
    else if (a == DEV_AD) r = RG_DEV;
    else if (a == USR_LO || a == USR_HI) r = RG_USER;
    else if (a == TSIG_LO || a == TSIG_HI) r = RG_TSIG;
    else if (a == SEC_AD || a == SEC_ALIAS) r = RG_SEC;
    else if (a == MFR2_AD) r = RG_MFR2;
    else if (a == DEV2_AD) r = RG_DEV2;
    return r;
  endfunction : sig_region

  function automatic logic sig_writable(input sig_region_e r, input logic otp);
    return (r == RG_TEST) || (r == RG_TSIG) || (r == RG_UDEF) ||
           (r == RG_USER && otp);
  endfunction : sig_writable
endpackage : sigsec_pkg

// [src/time_state_gen.sv]
`timescale 1ns/100ps
module time_state_gen
  import sigsec_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // prescaler hold
  input  wire logic       hold,
  // state outputs
  output logic      [2:0] ts_r,
  output logic      [1:0] ph_r
);
  // state 0 marks the held prescaler; release starts at state 1 phase 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ts_r <= 3'h0;
      ph_r <= 2'h0;
    end else if (hold) begin
      ts_r <= 3'h0;
      ph_r <= 2'h0;
    end else if (ts_r == 3'h0) begin
      ts_r <= 3'h1;
      ph_r <= 2'h1;
    end else if (ph_r == PHASES) begin
      ph_r <= 2'h1;
      ts_r <= (ts_r == STATES) ? 3'h1 : ts_r + 3'h1;
    end else begin
      ph_r <= ph_r + 2'h1;
    end
  end
endmodule : time_state_gen

// [testbench/sig_prog_model.sv]
`timescale 1ns/100ps
module sig_prog_model (
  // clock
  input  wire logic       pclk,
  // control pins
  output logic            chip_reset_pin,
  output logic            test_input_zero,
  output logic            sync_select_hv,
  output logic            program_enable_pin,
  output logic            prog_n,
  // address and data pins
  output logic      [7:0] bus_lines_in,
  input  wire logic [7:0] bus_lines_out,
  input  wire logic       bus_lines_oe,
  output logic      [7:0] port_one_in,
  output logic      [3:0] port_two_in
);
  logic [7:0] drv;
  logic       drv_en;

  // a released bus shows the inverse of the last value so stale data never matches
  assign bus_lines_in = bus_lines_oe ? bus_lines_out : (drv_en ? drv : ~drv);

  initial begin
    chip_reset_pin = 1'b0;
    test_input_zero = 1'b0;
    sync_select_hv = 1'b0;
    program_enable_pin = 1'b1;
    prog_n = 1'b1;
    port_one_in = 8'hff;
    port_two_in = 4'h0;
    drv = 8'h00;
    drv_en = 1'b0;
  end

  task automatic mode(input logic sig);
    port_one_in <= sig ? 8'hfe : 8'hff;
  endtask : mode

  task automatic latch(input logic [11:0] a);
    chip_reset_pin <= 1'b0;
    drv <= a[7:0];
    drv_en <= 1'b1;
    port_two_in <= a[11:8];
    @(posedge pclk);
    chip_reset_pin <= 1'b1;
    @(posedge pclk);
  endtask : latch

  task automatic verify(output logic [7:0] d);
    test_input_zero <= 1'b1;
    repeat (3) @(posedge pclk);
    d = bus_lines_in;
    test_input_zero <= 1'b0;
    @(posedge pclk);
  endtask : verify

  task automatic write_byte(input logic [11:0] a, input logic [7:0] v, output logic [7:0] d);
    latch(a);
    for (int n = 0; n < 25; n++) begin
      drv <= v;
      drv_en <= 1'b1;
      @(posedge pclk);
      prog_n <= 1'b0;
      @(posedge pclk);
      prog_n <= 1'b1;
      drv_en <= 1'b0;
      verify(d);
      if (d === v) break;
    end
  endtask : write_byte

  task automatic read_byte(input logic [11:0] a, output logic [7:0] d);
    latch(a);
    drv_en <= 1'b0;
    verify(d);
  endtask : read_byte

  task automatic sync_hold(input int n);
    program_enable_pin <= 1'b0;
    chip_reset_pin <= 1'b0;
    sync_select_hv <= 1'b1;
    repeat (4) @(posedge pclk);
    test_input_zero <= 1'b1;
    repeat (n) @(posedge pclk);
    test_input_zero <= 1'b0;
  endtask : sync_hold

  // call one clock before the drop is due: four clocks after test input falls
  task automatic sync_end();
    @(posedge pclk);
    sync_select_hv <= 1'b0;
    repeat (75) @(posedge pclk);
    chip_reset_pin <= 1'b1;
  endtask : sync_end
endmodule : sig_prog_model

// [testbench/sigsec_access_tb.sv]
`timescale 1ns/100ps
module sigsec_access_tb;
  import sigsec_pkg::*;
  localparam logic [7:0] MFR_V  = 8'h5a; // arbitrary value
  localparam logic [7:0] DEV_V  = 8'h3c; // arbitrary value
  localparam logic [7:0] MFR2_V = 8'h6b; // arbitrary value
  localparam logic [7:0] DEV2_V = 8'h4d; // arbitrary value

  typedef struct packed {logic [5:0] a; logic [7:0] v; logic [7:0] e;} row_s;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        crp, tiz, ssh, pep, prog_n, oe, er;
  logic [7:0]  bin, bout, p1, d;
  logic [3:0]  p2;
  logic [2:0]  time_state;
  logic [1:0]  time_phase;
  int          err_total;
  int          tests_run;

  row_s rows [11] = '{
    '{6'h05, 8'h11, 8'h11},
    '{6'h1e, 8'h22, 8'h22},
    '{6'h10, 8'h00, MFR_V},
    '{6'h11, 8'h00, DEV_V},
    '{6'h12, 8'ha5, 8'ha5},
    '{6'h14, 8'h3c, 8'h3c},
    '{6'h15, 8'hc3, 8'hc3},
    '{6'h20, 8'h00, MFR2_V},
    '{6'h21, 8'h00, DEV2_V},
    '{6'h22, 8'h77, 8'h77},
    '{6'h3e, 8'h55, 8'h55}
  };

  sigsec_access dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_reset_pin(crp), .test_input_zero(tiz), .sync_select_hv(ssh),
    .program_enable_pin(pep), .prog_n(prog_n), .bus_lines_in(bin), .bus_lines_out(bout),
    .bus_lines_oe(oe), .port_one_in(p1), .port_two_in(p2), .time_state(time_state),
    .time_phase(time_phase)
  );

  sig_prog_model pgm (
    .pclk(pclk), .chip_reset_pin(crp), .test_input_zero(tiz), .sync_select_hv(ssh),
    .program_enable_pin(pep), .prog_n(prog_n), .bus_lines_in(bin), .bus_lines_out(bout),
    .bus_lines_oe(oe), .port_one_in(p1), .port_two_in(p2)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_ts(input logic [2:0] t, input logic [1:0] p);
    #1;
    chk(32'({time_state, time_phase}), 32'({t, p}));
  endtask : chk_ts

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // far more than the slowest path of 25 pulses per fixed byte needs
  initial begin
    #2000000;
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(CTRL_OFF, 1'b0, 32'h0);
    chk(rd, 32'h1);
    apb(ADDR_OFF, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(8'h0c, 1'b0, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    pgm.mode(1'b1);
    foreach (rows[i]) begin
      pgm.write_byte({6'h00, rows[i].a}, rows[i].v, d);
      chk(32'(d), 32'(rows[i].e));
    end
    pgm.read_byte(12'h045, d);
    chk(32'(d), 32'h0);
    apb(CTRL_OFF, 1'b1, 32'h0);
    pgm.write_byte(12'h013, 8'h99, d);
    chk(32'(d), 32'h0);
    apb(CTRL_OFF, 1'b1, 32'h1);
    pgm.mode(1'b0);
    pgm.write_byte(12'h923, 8'h96, d);
    chk(32'(d), 32'h96);
    apb(ADDR_OFF, 1'b0, 32'h0);
    chk(rd, 32'h923);
    pgm.write_byte(12'h924, 8'h69, d);
    chk(32'(d), 32'h69);
    pgm.mode(1'b1);
    pgm.read_byte(12'h01f, d);
    chk(32'(d), 32'h0);
    pgm.write_byte(12'h01f, 8'hff, d);
    chk(32'(d), 32'hff);
    pgm.read_byte(12'h03f, d);
    chk(32'(d), 32'hff);
    apb(STAT_OFF, 1'b0, 32'h0);
    chk(32'(rd[ST_SEC]), 32'h1);
    pgm.mode(1'b0);
    pgm.read_byte(12'h923, d);
    chk(32'(d), 32'hff);
    pgm.read_byte(12'h924, d);
    chk(32'(d), 32'hff);
    pgm.mode(1'b1);
    pgm.read_byte(12'h012, d);
    chk(32'(d), 32'ha5);
    // port 2 low bits set: signature row not selected, the locked array answers
    pgm.read_byte(12'h112, d);
    chk(32'(d), 32'hff);
    // a two-clock pulse must not arm the prescaler reset
    pgm.sync_hold(2);
    repeat (8) @(posedge pclk);
    apb(STAT_OFF, 1'b0, 32'h0);
    chk(32'(rd[ST_ARM:ST_SYNC]), 32'h1);
    pgm.sync_hold(4);
    fork
      begin
        apb(STAT_OFF, 1'b0, 32'h0);
        chk(32'(rd[ST_ARM:ST_SYNC]), 32'h3);
      end
      begin
        repeat (2) @(posedge pclk);
        chk_ts(3'h0, 2'h0);
        @(posedge pclk);
        chk_ts(3'h1, 2'h1);
      end
    join
    fork
      pgm.sync_end();
      begin
        @(posedge pclk);
        chk_ts(3'h1, 2'h2);
        repeat (13) @(posedge pclk);
        chk_ts(3'h5, 2'h3);
        @(posedge pclk);
        chk_ts(3'h1, 2'h1);
      end
    join
    apb(STAT_OFF, 1'b0, 32'h0);
    chk(32'(rd[ST_ARM:ST_SYNC]), 32'h0);
    // reset in mid-run clears the security bit and restarts the time states
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'({time_state, time_phase, bout, oe, pready, pslverr}), 32'h0);
    chk(prdata, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_ts(3'h1, 2'h1);
    apb(STAT_OFF, 1'b0, 32'h0);
    chk(32'(rd[ST_SEC]), 32'h0);
    apb(CTRL_OFF, 1'b0, 32'h0);
    chk(rd, 32'h1);
    stop_test();
  end
endmodule : sigsec_access_tb
